//--- hw/ctmr_pkg.sv
// Purpose: Shared constants and types for the compact 16-bit timer.
// Assumes: One clock domain; register port is a plain address/strobe port.
// Notes:   Register indices are addresses on the 3-bit register port.

package ctmr_pkg;

    // ==================================================================
    // Register port and register indices
    // ==================================================================
    localparam int          ADDR_W     = 3;
    localparam int          DATA_W     = 8;
    localparam logic [2:0]  IDX_CTRL0  = 3'h0;
    localparam logic [2:0]  IDX_CTRL1  = 3'h1;
    localparam logic [2:0]  IDX_CNT_LO = 3'h2;
    localparam logic [2:0]  IDX_CNT_HI = 3'h3;
    localparam logic [2:0]  IDX_CMPA_LO = 3'h4;
    localparam logic [2:0]  IDX_CMPA_HI = 3'h5;
    localparam logic [2:0]  IDX_CMPP   = 3'h6;

    // ==================================================================
    // Field codes
    // ==================================================================
    localparam logic [1:0]  MODE_CMP   = 2'h0;
    localparam logic [1:0]  MODE_UNDEF = 2'h1;
    localparam logic [1:0]  MODE_PWM   = 2'h2;
    localparam logic [1:0]  MODE_TC    = 2'h3;
    localparam logic [1:0]  PIN_KEEP   = 2'h0;
    localparam logic [1:0]  PIN_LOW    = 2'h1;
    localparam logic [1:0]  PIN_HIGH   = 2'h2;
    localparam logic [1:0]  PIN_TOGGLE = 2'h3;
    localparam logic [1:0]  PWM_INACT  = 2'h0;
    localparam logic [1:0]  PWM_ACT    = 2'h1;
    localparam logic [1:0]  PWM_WAVE   = 2'h2;
    localparam logic [2:0]  CKS_SYS4   = 3'h0;
    localparam logic [2:0]  CKS_SYS    = 3'h1;
    localparam logic [2:0]  CKS_HI16   = 3'h2;
    localparam logic [2:0]  CKS_HI64   = 3'h3;
    localparam logic [2:0]  CKS_TBC    = 3'h4;
    localparam logic [2:0]  CKS_HI     = 3'h5;
    localparam logic [2:0]  CKS_PIN_R  = 3'h6;
    localparam logic [2:0]  CKS_PIN_F  = 3'h7;

    // ==================================================================
    // Counter, prescaler and reset constants
    // ==================================================================
    localparam int          CNT_W      = 16;
    localparam int          PRE_W      = 6;
    localparam logic [5:0]  PRE_DIV4   = 6'h03;
    localparam logic [5:0]  PRE_DIV16  = 6'h0F;
    localparam logic [5:0]  PRE_DIV64  = 6'h3F;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [16:0] SPAN_FULL  = 17'h1_0000;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ctmr_req_type;

    typedef struct packed {
        logic       pause;
        logic [2:0] cks;
        logic       on;
        logic [2:0] rsvd;
    } ctmr_ctrl0_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] pin_act;
        logic       init_lvl;
        logic       invert;
        logic       swap;
        logic       clr_on_a;
    } ctmr_ctrl1_type;

    typedef struct packed {
        ctmr_ctrl0_type    ctrl0;
        ctmr_ctrl1_type    ctrl1;
        logic [CNT_W-1:0]  cmp_a;
        logic [7:0]        cmp_p;
        logic [7:0]        byte_buf;
        logic [CNT_W-1:0]  cnt;
        logic [PRE_W-1:0]  pre;
        logic              ext_s1;
        logic              ext_s2;
        logic              ext_s3;
        logic              lvl;
        logic [DATA_W-1:0] rdata;
        logic              pin_o;
        logic              pin_oe_n;
        logic              evt_a;
        logic              evt_p;
    } ctmr_state_type;

    localparam ctmr_state_type STATE_RESET = '{
        ctrl0: '0, ctrl1: '0, cmp_a: CNT_ZERO, cmp_p: BYTE_ZERO,
        byte_buf: BYTE_ZERO, cnt: CNT_ZERO, pre: '0, ext_s1: 1'b0,
        ext_s2: 1'b0, ext_s3: 1'b0, lvl: 1'b0, rdata: BYTE_ZERO,
        pin_o: 1'b0, pin_oe_n: 1'b1, evt_a: 1'b0, evt_p: 1'b0};

endpackage

//--- hw/ctmr_core.sv
// Purpose: Compact 16-bit timer with compare output, counting and PWM.
// Assumes: The high internal clock runs at the system clock rate; the time
//          base arrives as a one-cycle enable from logic on this clock.
// Notes:   The external clock pin is synchronised before edge detection.
//
// Design decisions made here: strobed register access and the placing of the registers.

`timescale 1ns/100ps
`default_nettype none

module ctmr_core
    import ctmr_pkg::*;
(
    input  wire logic         clk,            // System clock, 250 MHz.
    input  wire logic         arst_n,         // Asynchronous reset, active low.
    input  wire ctmr_req_type req,            // Register port request.
    output logic [DATA_W-1:0] rdata,          // Read data, cycle after read.
    input  wire logic         time_base_tick, // Time base enable pulse.
    input  wire logic         ext_clk_pin,    // External clock pin.
    output logic              pin_o,          // Timer output pin level.
    output logic              pin_oe_n,       // Pin enable, low drives.
    output logic              match_a_evt,    // Match A event pulse.
    output logic              match_p_evt     // Match P event pulse.
);

    // ==================================================================
    // State
    // ==================================================================
    ctmr_state_type st_r;
    ctmr_state_type st_nxt;

    logic        src_en;
    logic        ext_rise;
    logic        ext_fall;
    logic        on_rise;
    logic        tick;
    logic        is_pwm;
    logic        hit_a;
    logic        hit_p;
    logic        clr_by_a;
    logic        clear;
    logic        raise_p;
    logic [15:0] cnt_inc;
    logic [16:0] span_a;
    logic [16:0] span_p;
    logic [16:0] period;
    logic [16:0] duty;
    logic        pwm_active;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = BYTE_ZERO;

        // Prescaler runs freely so divided rates keep phase while stopped.
        st_nxt.pre = PRE_W'(st_r.pre + 1'b1);

        // Only the second stage and later are looked at.
        st_nxt.ext_s1 = ext_clk_pin;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        ext_rise = st_r.ext_s2 & ~st_r.ext_s3;
        ext_fall = ~st_r.ext_s2 & st_r.ext_s3;

        // ==============================================================
        // Clock source select
        // ==============================================================
        // clock source choice
        case (st_r.ctrl0.cks)
            CKS_SYS4:  src_en = (st_r.pre[1:0] == PRE_DIV4[1:0]);
            CKS_SYS:   src_en = 1'b1;
            CKS_HI16:  src_en = (st_r.pre[3:0] == PRE_DIV16[3:0]);
            CKS_HI64:  src_en = (st_r.pre == PRE_DIV64);
            CKS_TBC:   src_en = time_base_tick;
            CKS_HI:    src_en = 1'b1;
            CKS_PIN_R: src_en = ext_rise;
            CKS_PIN_F: src_en = ext_fall;
            default:   src_en = 1'b0;
        endcase

        on_rise = req.wr && (req.addr == IDX_CTRL0) && req.wdata[3] && !st_r.ctrl0.on;
        tick = st_r.ctrl0.on & ~st_r.ctrl0.pause & src_en;
        cnt_inc = st_r.cnt + CNT_ONE;
        is_pwm = (st_r.ctrl1.mode == MODE_PWM);

        // ==============================================================
        // Comparators
        // ==============================================================
        // comparator widths
        hit_a = tick && (st_r.cmp_a != CNT_ZERO) && (cnt_inc == st_r.cmp_a);
        hit_p = tick && (cnt_inc[7:0] == BYTE_ZERO) && (cnt_inc[15:8] == st_r.cmp_p);
        clr_by_a = is_pwm ? st_r.ctrl1.swap : st_r.ctrl1.clr_on_a;
        clear = clr_by_a ? hit_a : hit_p;
        raise_p = hit_p && (is_pwm || !st_r.ctrl1.clr_on_a);

        if (on_rise) begin
            st_nxt.cnt = CNT_ZERO;
        end else if (tick) begin
            st_nxt.cnt = clear ? CNT_ZERO : cnt_inc;
        end
        st_nxt.evt_a = hit_a;
        st_nxt.evt_p = raise_p;

        // ==============================================================
        // PWM period and duty
        // ==============================================================
        // period and duty swap
        span_a = {1'b0, st_r.cmp_a};
        span_p = (st_r.cmp_p == BYTE_ZERO) ? SPAN_FULL : {1'b0, st_r.cmp_p, BYTE_ZERO};
        period = st_r.ctrl1.swap ? span_a : span_p;
        duty = st_r.ctrl1.swap ? span_p : span_a;
        // full duty falls out since the count never reaches period
        pwm_active = ({1'b0, st_r.cnt} < duty);

        // ==============================================================
        // Output level
        // ==============================================================
        // mode decode
        case (st_r.ctrl1.mode)
            MODE_CMP: begin
                if (on_rise) begin
                    st_nxt.lvl = st_r.ctrl1.init_lvl;
                end else if (hit_a) begin
                    case (st_r.ctrl1.pin_act)
                        PIN_LOW:    st_nxt.lvl = 1'b0;
                        PIN_HIGH:   st_nxt.lvl = 1'b1;
                        PIN_TOGGLE: st_nxt.lvl = ~st_r.lvl;
                        default:    st_nxt.lvl = st_r.lvl;
                    endcase
                end
            end
            MODE_PWM: begin
                case (st_r.ctrl1.pin_act)
                    PWM_ACT:  st_nxt.lvl = st_r.ctrl1.init_lvl;
                    PWM_WAVE: st_nxt.lvl = pwm_active ? st_r.ctrl1.init_lvl : ~st_r.ctrl1.init_lvl;
                    default:  st_nxt.lvl = ~st_r.ctrl1.init_lvl;
                endcase
            end
            MODE_UNDEF: st_nxt.lvl = 1'b0;
            default:    st_nxt.lvl = st_r.lvl;
        endcase

        // ==============================================================
        // Register port
        // ==============================================================
        // control changes while running are the caller's concern
        if (req.wr) begin
            case (req.addr)
                IDX_CTRL0:   st_nxt.ctrl0 = {req.wdata[7:3], 3'h0};
                IDX_CTRL1:   st_nxt.ctrl1 = req.wdata;
                IDX_CMPA_LO: st_nxt.byte_buf = req.wdata;
                IDX_CMPA_HI: st_nxt.cmp_a = {req.wdata, st_r.byte_buf};
                IDX_CMPP:    st_nxt.cmp_p = req.wdata;
                default:     st_nxt.byte_buf = st_r.byte_buf;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                IDX_CTRL0:   st_nxt.rdata = st_r.ctrl0;
                IDX_CTRL1:   st_nxt.rdata = st_r.ctrl1;
                // high byte read latches low byte
                IDX_CNT_HI: begin
                    st_nxt.rdata = st_r.cnt[15:8];
                    st_nxt.byte_buf = st_r.cnt[7:0];
                end
                IDX_CMPA_HI: begin
                    st_nxt.rdata = st_r.cmp_a[15:8];
                    st_nxt.byte_buf = st_r.cmp_a[7:0];
                end
                IDX_CNT_LO:  st_nxt.rdata = st_r.byte_buf;
                IDX_CMPA_LO: st_nxt.rdata = st_r.byte_buf;
                IDX_CMPP:    st_nxt.rdata = st_r.cmp_p;
                default:     st_nxt.rdata = BYTE_ZERO;
            endcase
        end

        st_nxt.pin_o = st_nxt.lvl ^ st_nxt.ctrl1.invert;
        st_nxt.pin_oe_n = (st_nxt.ctrl1.mode == MODE_TC);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata       = st_r.rdata;
    assign pin_o       = st_r.pin_o;
    assign pin_oe_n    = st_r.pin_oe_n;
    assign match_a_evt = st_r.evt_a;
    assign match_p_evt = st_r.evt_p;

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_cmpa_lo_write;
        req.wr && (req.addr == IDX_CMPA_LO);
    endsequence

    sequence s_cmpa_hi_write;
        req.wr && (req.addr == IDX_CMPA_HI);
    endsequence

    chk_on_clears_count: assert property (on_rise |=> st_r.cnt == CNT_ZERO)
        else $error("Counter not cleared by timer-on rising edge.");

    chk_pause_holds: assert property (st_r.ctrl0.pause && !on_rise |=> $stable(st_r.cnt))
        else $error("Counter moved while paused.");

    chk_off_holds: assert property (!st_r.ctrl0.on && !on_rise |=> $stable(st_r.cnt))
        else $error("Counter moved while timer is off.");

    chk_match_clears: assert property (clear |=> st_r.cnt == CNT_ZERO ##0 (st_r.evt_a || st_r.evt_p))
        else $error("Match did not clear counter or raise event.");

    chk_no_p_event: assert property (!is_pwm && st_r.ctrl1.clr_on_a |=> !st_r.evt_p)
        else $error("Match P event raised with clear source on A.");

    chk_tc_undriven: assert property (st_r.ctrl1.mode == MODE_TC |-> st_r.pin_oe_n)
        else $error("Pin driven in timer/counter mode.");

    chk_pin_invert: assert property (st_r.pin_o == (st_r.lvl ^ st_r.ctrl1.invert))
        else $error("Pin level does not follow polarity.");

    chk_toggle_on_a: assert property (st_r.ctrl1.mode == MODE_CMP && st_r.ctrl1.pin_act == PIN_TOGGLE
                                      && hit_a && !on_rise |=> st_r.lvl != $past(st_r.lvl))
        else $error("Match A did not toggle the output.");

    chk_pwm_full: assert property (is_pwm && st_r.ctrl1.pin_act == PWM_WAVE && duty >= period
                                   && $stable(st_r.ctrl1) && !(req.wr && req.addr == IDX_CTRL1)
                                   |=> st_r.lvl == st_r.ctrl1.init_lvl)
        else $error("PWM output not full duty.");

    chk_buffer_commit: assert property (s_cmpa_lo_write ##1 s_cmpa_hi_write
                                        |=> st_r.cmp_a[7:0] == $past(req.wdata, 2))
        else $error("Compare A low byte not committed from buffer.");

    chk_ext_rise_ticks: assert property (st_r.ctrl0.cks == CKS_PIN_R && st_r.ctrl0.on && !st_r.ctrl0.pause
                                         && ext_rise && !req.wr |=> st_r.cnt != $past(st_r.cnt))
        else $error("Counter missed external rising edge.");

endmodule // ctmr_core

`default_nettype wire

//--- verification/ctmr_core_test.sv
// Purpose: Self-checking bench for the compact 16-bit timer core.
// Assumes: Register port reads answer one cycle after the read strobe.
// Notes:   Time base ticks and the external pin edges come every 8 clocks.

`timescale 1ns/100ps
`default_nettype none

module ctmr_core_test
    import ctmr_pkg::*;
;
    logic              clk;
    logic              arst_n;
    ctmr_req_type      req;
    logic [DATA_W-1:0] rdata;
    logic              time_base_tick;
    logic              ext_clk_pin;
    logic              pin_o;
    logic              pin_oe_n;
    logic              match_a_evt;
    logic              match_p_evt;
    logic [2:0]        div_cnt;
    int                fail_count;
    int                check_count;
    int                n_a;
    int                n_p;
    int                n_hi;
    int                n_chg;

    ctmr_core u_ctmr_core (
        .clk            (clk),
        .arst_n         (arst_n),
        .req            (req),
        .rdata          (rdata),
        .time_base_tick (time_base_tick),
        .ext_clk_pin    (ext_clk_pin),
        .pin_o          (pin_o),
        .pin_oe_n       (pin_oe_n),
        .match_a_evt    (match_a_evt),
        .match_p_evt    (match_p_evt)
    );

    // ==================================================================
    // Clock and free-running slow sources
    // ==================================================================
    always #2 clk = ~clk;

    always @(posedge clk) begin
        div_cnt <= div_cnt + 3'h1;
        time_base_tick <= (div_cnt == 3'h7);
        if (div_cnt == 3'h7) begin
            ext_clk_pin <= ~ext_clk_pin;
        end
    end

    // ==================================================================
    // Bus and compare helpers
    // ==================================================================
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask

    task automatic read_count(output logic [15:0] v);
        bus_rd(IDX_CNT_HI, v[15:8]);
        bus_rd(IDX_CNT_LO, v[7:0]);
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_near(input int got, input int exp, input int tol);
        check_count++;
        if (got < exp - tol || got > exp + tol) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reconfigures only while stopped, since mode changes on a running timer are unreliable.
    // stop before reconfig
    task automatic run_case(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                            input logic [2:0] cks, input int win);
        logic prev;
        bus_wr(IDX_CTRL0, 8'h10);
        bus_wr(IDX_CTRL1, c1);
        bus_wr(IDX_CMPA_LO, a[7:0]);
        bus_wr(IDX_CMPA_HI, a[15:8]);
        bus_wr(IDX_CMPP, p);
        bus_wr(IDX_CTRL0, {1'b0, cks, 1'b1, 3'b000});
        repeat (3) @(posedge clk);
        #1 prev = pin_o;
        n_a = 0;
        n_p = 0;
        n_hi = 0;
        n_chg = 0;
        repeat (win) begin
            @(posedge clk);
            #1;
            n_a += int'(match_a_evt === 1'b1);
            n_p += int'(match_p_evt === 1'b1);
            n_hi += int'(pin_o === 1'b1);
            n_chg += int'(pin_o !== prev);
            prev = pin_o;
        end
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic test_regs();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            bus_rd(3'(i), d);
            check16({8'h00, d}, 16'h0000);
        end
        check16({15'h0000, pin_oe_n}, 16'h0000);
        bus_wr(IDX_CTRL0, 8'hE7);
        bus_rd(IDX_CTRL0, d);
        check16({8'h00, d}, 16'h00E0);
        bus_wr(IDX_CTRL1, 8'hA5);
        bus_rd(IDX_CTRL1, d);
        check16({8'h00, d}, 16'h00A5);
        bus_wr(IDX_CMPP, 8'h5A);
        bus_rd(IDX_CMPP, d);
        check16({8'h00, d}, 16'h005A);
        bus_wr(3'h7, 8'hFF);
        bus_rd(3'h7, d);
        check16({8'h00, d}, 16'h0000);
        $display("Test registers finished");
    endtask

    task automatic test_buffer();
        logic [7:0]  d;
        logic [15:0] v;
        bus_wr(IDX_CMPA_LO, 8'h34);
        bus_rd(IDX_CMPA_HI, d);
        check16({8'h00, d}, 16'h0000);
        bus_rd(IDX_CMPA_LO, d);
        check16({8'h00, d}, 16'h0000);
        bus_wr(IDX_CMPA_LO, 8'h34);
        bus_wr(IDX_CMPA_HI, 8'h12);
        bus_rd(IDX_CMPA_HI, v[15:8]);
        bus_rd(IDX_CMPA_LO, v[7:0]);
        check16(v, 16'h1234);
        bus_wr(IDX_CNT_LO, 8'h55);
        bus_wr(IDX_CNT_HI, 8'h66);
        read_count(v);
        check16(v, 16'h0000);
        $display("Test buffer finished");
    endtask

    task automatic test_compare();
        logic [7:0]  c1s [0:5] = '{8'h39, 8'h24, 8'h29, 8'h19, 8'h09, 8'hC1};
        logic [15:0] as  [0:5] = '{16'h0005, 16'h0010, 16'h0008, 16'h0008, 16'h0008, 16'h0008};
        int          wins[0:5] = '{50, 512, 64, 64, 64, 64};
        int          eas [0:5] = '{10, 2, 8, 8, 8, 8};
        int          eps [0:5] = '{0, 2, 0, 0, 0, 0};
        int          ecs [0:5] = '{10, 1, 0, 1, 0, 0};
        logic        eps_pin [0:5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            run_case(c1s[i], as[i], (i == 1) ? 8'h01 : 8'h00, CKS_SYS, wins[i]);
            check_near(n_a, eas[i], 0);
            check_near(n_p, eps[i], 0);
            check16({15'h0000, pin_oe_n}, {15'h0000, c1s[i][7:6] == MODE_TC});
            if (c1s[i][7:6] != MODE_TC) begin
                check_near(n_chg, ecs[i], 0);
            end
            if (c1s[i][7:6] != MODE_TC && c1s[i][5:4] != PIN_TOGGLE) begin
                check16({15'h0000, pin_o}, {15'h0000, eps_pin[i]});
            end
        end
        $display("Test compare finished");
    endtask

    task automatic test_pwm();
        logic [7:0]  c1s [0:8] = '{8'h88, 8'h98, 8'hB8, 8'hA8, 8'hA0, 8'hA4, 8'h48, 8'hA8, 8'hAA};
        logic [15:0] as  [0:8] = '{16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0040,
                                   16'h0040, 16'h0100, 16'h0200};
        int          wins[0:8] = '{256, 256, 256, 256, 256, 256, 256, 256, 512};
        int          ehs [0:8] = '{0, 256, 0, 64, 192, 64, 0, 256, 256};
        for (int i = 0; i < 9; i++) begin
            run_case(c1s[i], as[i], 8'h01, CKS_SYS, wins[i]);
            check_near(n_hi, ehs[i], 0);
        end
        $display("Test pwm finished");
    endtask

    task automatic test_clocks();
        int exps [0:7] = '{64, 256, 16, 4, 32, 256, 16, 16};
        for (int i = 0; i < 8; i++) begin
            run_case(8'hC1, 16'h0004, 8'h00, 3'(i), 1024);
            check_near(n_a, exps[i], 1);
        end
        $display("Test clocks finished");
    endtask

    task automatic test_pause();
        logic [15:0] v1;
        logic [15:0] v2;
        run_case(8'hC0, 16'h0000, 8'h00, CKS_SYS, 40);
        bus_wr(IDX_CTRL0, 8'h98);
        read_count(v1);
        repeat (20) @(posedge clk);
        read_count(v2);
        check16(v2, v1);
        check16({15'h0000, v1 != 16'h0000}, 16'h0001);
        bus_wr(IDX_CTRL0, 8'h18);
        repeat (20) @(posedge clk);
        read_count(v2);
        check16({15'h0000, v2 > v1 + 16'h0014}, 16'h0001);
        bus_wr(IDX_CTRL0, 8'h10);
        read_count(v1);
        repeat (20) @(posedge clk);
        read_count(v2);
        check16(v2, v1);
        bus_wr(IDX_CTRL0, 8'h98);
        read_count(v2);
        check16(v2, 16'h0000);
        $display("Test pause finished");
    endtask

    // ==================================================================
    // Verdict, watchdog and main sequence
    // ==================================================================
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole run needs about 12k clocks, so this limit only trips on a hang.
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        req = '0;
        time_base_tick = 1'b0;
        ext_clk_pin = 1'b0;
        div_cnt = 3'h0;
        fail_count = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        test_regs();
        test_buffer();
        test_compare();
        test_pwm();
        test_clocks();
        test_pause();
        complete_run();
    end

endmodule // ctmr_core_test

`default_nettype wire
